// *** design/tamper_pulse_pkg.sv ***
/*
 Constants shared by the tamper channel selector and energy pulse block:
 register offsets, field positions, reset values and timing figures.
 Assumes a 40 MHz system clock and 24-bit fixed-point power words.
*/
package tamper_pulse_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 24;
   localparam int NGEN = 3;
   localparam logic [5:0] ADDR_CFG_TWO = 6'h00;
   localparam logic [5:0] ADDR_CFG_ONE = 6'h01;
   localparam logic [5:0] ADDR_MIN_AMP = 6'h03;
   localparam logic [5:0] ADDR_CHAN_LEVEL = 6'h04;
   localparam logic [5:0] ADDR_FIXED_VOLTAGE_SUBSTITUTE_VALUE = 6'h05;
   localparam logic [5:0] ADDR_PULSE_WIDTH = 6'h08;
   localparam logic [5:0] ADDR_PULSE_SEL = 6'h09;
   localparam logic [5:0] ADDR_PULSE_RATE = 6'h1c;
   // general_config_two fields.
   localparam int C2_TOPO_LSB = 0;
   localparam int C2_CMP_BIT = 2;
   localparam int C2_HOLD_BIT = 3;
   localparam int C2_FORCE_BIT = 4;
   localparam int C2_FIXED_VOLTAGE_SUBSTITUTE_BIT = 5;
   localparam int C2_ACTIVE_BIT = 8;
   localparam logic [1:0] TOPO_LPN = 2'b00;
   // general_config_one fields: pin p mode at MODE_W*p, enables at EN_LSB.
   localparam int MODE_W = 4;
   localparam int EN_LSB = 16;
   localparam logic [3:0] MODE_HIZ = 4'h0;
   localparam logic [3:0] MODE_EPG_BASE = 4'h1;
   // pulse_width_range fields.
   localparam int PW_LSB = 0;
   localparam int PW_W = 20;
   localparam int RNG_LSB = 20;
   localparam int RNG_W = 4;
   // pulse_input_select: SEL_W bits per generator.
   localparam int SEL_W = 2;
   localparam logic [1:0] SEL_REACTIVE = 2'd1;
   localparam logic [1:0] SEL_APPARENT = 2'd2;
   localparam logic [23:0] CFG_TWO_RST = 24'h00_0000;
   localparam logic [23:0] CFG_ONE_RST = 24'h00_0000;
   localparam logic [23:0] MIN_AMP_RST = 24'h00_0000;
   localparam logic [23:0] LEVEL_RST = 24'h41_47AE;
   localparam logic [23:0] FIXED_VOLTAGE_SUBSTITUTE_RST = 24'hB5_04F7;
   localparam logic [23:0] PW_RST = 24'h00_0001;
   localparam logic [23:0] SEL_RST = 24'h00_0000;
   localparam logic [23:0] RATE_RST = 24'h00_0000;
   localparam int LEVEL_FRAC = 22;
   localparam int FIXED_VOLTAGE_SUBSTITUTE_SHIFT = 25;
   // Timing: base low time, width step and full-scale pulse frequency.
   localparam int unsigned PULSE_BASE_NS = 250_000;
   localparam int unsigned PULSE_BASE_CYC =
      (PULSE_BASE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned PW_DIV = 64000;
   localparam int unsigned PW_CYC_PER_LSB = CLK_HZ / PW_DIV;
   localparam int unsigned FS_HZ = 2000;
   localparam int unsigned FS_CYC = CLK_HZ / FS_HZ;
   localparam int POWER_FS_SHIFT = 2 * DATA_W - 1;
   localparam int ACC_W = 80;
endpackage

// *** design/tamper_select_energy_pulse.sv ***
/*
 Current channel selection with tamper correction, fixed-voltage active
 power substitution, and three energy pulse generators on three pins.
 Assumes the DSP supplies power and RMS words on the same clock with a
 sample_valid strobe, and a serial engine drives the register port.
*/
// Function
// - Neutral mode takes total powers from one chosen current channel.
// - Automatic mode routes the larger-magnitude channel to the totals.
// - Compare-select bit 0 compares active power, 1 compares RMS current.
// - No automatic change unless a channel exceeds the minimum amplitude.
// - Switch only when other channel exceeds active times the level.
// - Manual hold stops auto selection; forced bit names the channel.
// - Fixed-voltage bit substitutes the programmable RMS voltage value.
// - Substitution touches active power only, not reactive or apparent.
// - Three generators, any pin, frequency proportional to power magnitude.
// - After reset generators off and every pin mode high impedance.
// - Pulse select register picks active, reactive or apparent per generator.
// - Full-scale frequency equals rate times 2000 over two to range.
// - Pulse low time is 250 us plus width over 64000 seconds.
// - Pulse width resets to one, giving about 265.6 us low time.
module tamper_select_energy_pulse
   import tamper_pulse_pkg::*;
#(
   parameter int unsigned BASE_CYCLES = PULSE_BASE_CYC,
   parameter int unsigned FS_CYCLES = FS_CYC
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [5:0] reg_addr,
   input wire logic [23:0] reg_wdata,
   output logic [23:0] reg_rdata,
   input wire logic sample_valid,
   input wire logic signed [23:0] p1_avg,
   input wire logic signed [23:0] p2_avg,
   input wire logic signed [23:0] q1_avg,
   input wire logic signed [23:0] q2_avg,
   input wire logic signed [23:0] s1_avg,
   input wire logic signed [23:0] s2_avg,
   input wire logic [23:0] i1_rms,
   input wire logic [23:0] i2_rms,
   output logic signed [23:0] psum,
   output logic signed [23:0] qsum,
   output logic signed [23:0] ssum,
   output logic active_chan,
   output logic [2:0] do_out,
   output logic [2:0] do_oe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   function automatic logic [23:0] mag24(input logic signed [23:0] v);
      return v[23] ? 24'(-v) : 24'(v);
   endfunction

   function automatic logic signed [23:0] half_sum(
      input logic signed [23:0] a, input logic signed [23:0] b);
      logic signed [24:0] s;
      s = 25'(a) + 25'(b);
      return s[24:1];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register file.
   logic [23:0] cfg_two_r, cfg_one_r, min_amp_r, chan_level_r;
   logic [23:0] fixed_voltage_substitute_value_r, pw_r, sel_r, rate_r, rd_mux;
   logic active_r;
   wire wr_two = reg_wr && (reg_addr == ADDR_CFG_TWO);
   wire wr_one = reg_wr && (reg_addr == ADDR_CFG_ONE);
   wire wr_min = reg_wr && (reg_addr == ADDR_MIN_AMP);
   wire wr_lvl = reg_wr && (reg_addr == ADDR_CHAN_LEVEL);
   wire wr_vfx = reg_wr && (reg_addr == ADDR_FIXED_VOLTAGE_SUBSTITUTE_VALUE);
   wire wr_pw = reg_wr && (reg_addr == ADDR_PULSE_WIDTH);
   wire wr_sel = reg_wr && (reg_addr == ADDR_PULSE_SEL);
   wire wr_rate = reg_wr && (reg_addr == ADDR_PULSE_RATE);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cfg_two_r <= CFG_TWO_RST;
         cfg_one_r <= CFG_ONE_RST;
         min_amp_r <= MIN_AMP_RST;
         chan_level_r <= LEVEL_RST;
         fixed_voltage_substitute_value_r <= FIXED_VOLTAGE_SUBSTITUTE_RST;
         pw_r <= PW_RST;
         sel_r <= SEL_RST;
         rate_r <= RATE_RST;
      end else begin
         if (wr_two) cfg_two_r <= reg_wdata;
         if (wr_one) cfg_one_r <= reg_wdata;
         if (wr_min) min_amp_r <= reg_wdata;
         if (wr_lvl) chan_level_r <= reg_wdata;
         if (wr_vfx) fixed_voltage_substitute_value_r <= reg_wdata;
         if (wr_pw) pw_r <= reg_wdata;
         if (wr_sel) sel_r <= reg_wdata;
         if (wr_rate) rate_r <= reg_wdata;
      end
   end

   // The active channel bit reads back live so software can see a switch.
   always_comb begin
      rd_mux = '0;
      case (reg_addr)
         ADDR_CFG_TWO: begin
            rd_mux = cfg_two_r;
            rd_mux[C2_ACTIVE_BIT] = active_r;
         end
         ADDR_CFG_ONE: rd_mux = cfg_one_r;
         ADDR_MIN_AMP: rd_mux = min_amp_r;
         ADDR_CHAN_LEVEL: rd_mux = chan_level_r;
         ADDR_FIXED_VOLTAGE_SUBSTITUTE_VALUE: rd_mux = fixed_voltage_substitute_value_r;
         ADDR_PULSE_WIDTH: rd_mux = pw_r;
         ADDR_PULSE_SEL: rd_mux = sel_r;
         ADDR_PULSE_RATE: rd_mux = rate_r;
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) reg_rdata <= '0;
      else if (reg_rd) reg_rdata <= rd_mux;
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel selection and fixed-voltage substitution.
   wire [1:0] topo = cfg_two_r[C2_TOPO_LSB +: 2];
   wire cmp_irms = cfg_two_r[C2_CMP_BIT];
   wire hold = cfg_two_r[C2_HOLD_BIT];
   wire force_chan = cfg_two_r[C2_FORCE_BIT];
   wire fixed_voltage_substitute = cfg_two_r[C2_FIXED_VOLTAGE_SUBSTITUTE_BIT];
   wire [47:0] vprod1 = fixed_voltage_substitute_value_r * i1_rms;
   wire [47:0] vprod2 = fixed_voltage_substitute_value_r * i2_rms;
   // The substitute has no sign: a fixed voltage carries no phase.
   wire signed [23:0] p1_eff = fixed_voltage_substitute ? {1'b0, vprod1[FIXED_VOLTAGE_SUBSTITUTE_SHIFT +: 23]}
                                    : p1_avg;
   wire signed [23:0] p2_eff = fixed_voltage_substitute ? {1'b0, vprod2[FIXED_VOLTAGE_SUBSTITUTE_SHIFT +: 23]}
                                    : p2_avg;
   wire [23:0] cmp1 = cmp_irms ? i1_rms : mag24(p1_eff);
   wire [23:0] cmp2 = cmp_irms ? i2_rms : mag24(p2_eff);
   wire above_min = (cmp1 > min_amp_r) || (cmp2 > min_amp_r);
   wire [23:0] act_q = active_r ? cmp2 : cmp1;
   wire [23:0] oth_q = active_r ? cmp1 : cmp2;
   wire [47:0] act_scaled = (act_q * chan_level_r) >> LEVEL_FRAC;
   wire other_bigger = {24'h00_0000, oth_q} > act_scaled;
   wire auto_switch = (topo == TOPO_LPN) && above_min && other_bigger;
   wire chan_nxt = hold ? force_chan
                 : (auto_switch ? ~active_r : active_r);
   wire signed [23:0] psel = chan_nxt ? p2_eff : p1_eff;
   wire signed [23:0] qsel = chan_nxt ? q2_avg : q1_avg;
   wire signed [23:0] ssel = chan_nxt ? s2_avg : s1_avg;
   wire lpn = (topo == TOPO_LPN);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         active_r <= 1'b0;
         psum <= '0;
         qsum <= '0;
         ssum <= '0;
      end else if (sample_valid) begin
         active_r <= chan_nxt;
         psum <= lpn ? psel : half_sum(p1_eff, p2_eff);
         qsum <= lpn ? qsel : half_sum(q1_avg, q2_avg);
         ssum <= lpn ? ssel : half_sum(s1_avg, s2_avg);
      end
   end
   assign active_chan = active_r;

   AST_HOLD_FORCES: assert property (sample_valid && hold
      |=> active_r == $past(force_chan))
      else $error("manual hold did not force the channel");
   AST_BELOW_MIN_STAYS: assert property (sample_valid && !hold
      && !above_min |=> $stable(active_r))
      else $error("channel changed below minimum amplitude");
   AST_HYSTERESIS: assert property (sample_valid && !hold
      && !other_bigger |=> $stable(active_r))
      else $error("channel changed inside hysteresis band");
   AST_AUTO_SWITCH: assert property (sample_valid && !hold && lpn
      && above_min && other_bigger |=> active_r != $past(active_r))
      else $error("larger channel was not selected");
   AST_LPN_SUM: assert property (sample_valid && lpn
      |=> psum == $past(chan_nxt ? p2_eff : p1_eff))
      else $error("total active power not from the chosen channel");
   AST_FIXED_VOLTAGE_SUBSTITUTE_ACTIVE: assert property (sample_valid && lpn && fixed_voltage_substitute
      && !chan_nxt |=> psum == {1'b0, $past(vprod1[FIXED_VOLTAGE_SUBSTITUTE_SHIFT +: 23])})
      else $error("fixed voltage not used in active power");
   AST_FIXED_VOLTAGE_SUBSTITUTE_REACTIVE: assert property (sample_valid && lpn && fixed_voltage_substitute
      && chan_nxt |=> qsum == $past(q2_avg) && ssum == $past(s2_avg))
      else $error("fixed voltage leaked into other powers");
   COV_SWITCH: cover property (sample_valid && auto_switch && !hold);
   COV_FIXED_VOLTAGE_SUBSTITUTE: cover property (sample_valid && fixed_voltage_substitute && lpn);

   ////////////////////////////////////////////////////////////////////////
   // Energy pulse generators and pin routing.
   logic [ACC_W-1:0] acc_r [NGEN];
   logic [31:0] low_cnt_r [NGEN];
   logic [NGEN-1:0] gen_low_r;
   wire [RNG_W-1:0] rng = pw_r[RNG_LSB +: RNG_W];
   wire [31:0] low_cycles = BASE_CYCLES
      + 32'(pw_r[PW_LSB +: PW_W]) * PW_CYC_PER_LSB;
   wire [ACC_W-1:0] thresh =
      ACC_W'(FS_CYCLES) << (POWER_FS_SHIFT + int'(rng));

   for (genvar g = 0; g < NGEN; g++) begin : gen_epg
      wire [1:0] sel = sel_r[SEL_W*g +: SEL_W];
      wire signed [23:0] src = (sel == SEL_REACTIVE) ? qsum
                             : (sel == SEL_APPARENT) ? ssum : psum;
      wire [47:0] inc = mag24(src) * rate_r;
      wire [ACC_W-1:0] sum = acc_r[g] + ACC_W'(inc);
      wire en = cfg_one_r[EN_LSB + g];
      wire fire = en && (sum >= thresh);
      always_ff @(posedge clock or negedge nrst) begin
         if (!nrst) begin
            acc_r[g] <= '0;
            gen_low_r[g] <= 1'b0;
            low_cnt_r[g] <= '0;
         end else if (!en) begin
            acc_r[g] <= '0;
            gen_low_r[g] <= 1'b0;
            low_cnt_r[g] <= '0;
         end else begin
            acc_r[g] <= fire ? sum - thresh : sum;
            if (gen_low_r[g]) begin
               gen_low_r[g] <= (low_cnt_r[g] != '0);
               low_cnt_r[g] <= low_cnt_r[g] - 32'd1;
            end else if (fire) begin
               gen_low_r[g] <= 1'b1;
               low_cnt_r[g] <= low_cycles - 32'd1;
            end
         end
      end
   end

   for (genvar p = 0; p < NGEN; p++) begin : gen_pin
      wire [3:0] mode = cfg_one_r[MODE_W*p +: MODE_W];
      wire [3:0] idx = mode - MODE_EPG_BASE;
      wire drive = (mode >= MODE_EPG_BASE)
                && (idx < 4'(NGEN));
      always_ff @(posedge clock or negedge nrst) begin
         if (!nrst) begin
            do_oe[p] <= 1'b0;
            do_out[p] <= 1'b1;
         end else begin
            do_oe[p] <= drive;
            do_out[p] <= drive ? !gen_low_r[idx[1:0]] : 1'b1;
         end
      end
   end

   AST_HIZ_PIN: assert property (cfg_one_r[MODE_W-1:0] == MODE_HIZ
      |=> !do_oe[0])
      else $error("pin driven while mode is high impedance");
   AST_PULSE_START: assert property (gen_epg[0].fire && !gen_low_r[0]
      |=> gen_low_r[0] && low_cnt_r[0] == $past(low_cycles) - 32'd1)
      else $error("pulse low time loaded wrong");
   AST_PULSE_END: assert property (gen_low_r[0] && low_cnt_r[0] == '0
      && cfg_one_r[EN_LSB] |=> !gen_low_r[0])
      else $error("pulse did not end on time");
   AST_ACC_BOUND: assert property (cfg_one_r[EN_LSB]
      |=> acc_r[0] < $past(thresh))
      else $error("pulse accumulator passed its threshold");
   AST_DISABLED_IDLE: assert property (!cfg_one_r[EN_LSB]
      |=> acc_r[0] == '0 && !gen_low_r[0])
      else $error("disabled generator still running");
   COV_PULSE: cover property (gen_epg[0].fire && !gen_low_r[0]);
   COV_PIN_LOW: cover property (do_oe[0] && !do_out[0]);
endmodule

// *** verification/host_model.sv ***
/*
 Host model: drives the register port, then counts energy pulses on pins.
 Assumes the block takes strobes on the rising edge of clock.
*/
module host_model
   import tamper_pulse_pkg::*;
#(
   parameter int WAIT_CYC = 100
) (
   input wire logic clock,
   output logic reg_wr,
   output logic reg_rd,
   output logic [5:0] reg_addr,
   output logic [23:0] reg_wdata,
   input wire logic [23:0] reg_rdata,
   input wire logic [2:0] do_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cyc = 0;
   int fall_at[3];
   int period[3];
   int low_len[3];
   int pulses[3];
   logic [2:0] prev = 3'b111;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 24'h00_0000;
   end
   ////////////////////////////////////////////////////////////////////////
   // Released address and data flip, so a stale value never looks valid.
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(negedge clock);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [23:0] d);
      @(negedge clock);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clock);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
   // WAIT_CYC stands in for the long settling wait, to keep runs short.
   task automatic pulse_setup(input logic [23:0] pw, rate, sel, en);
      wr(ADDR_PULSE_WIDTH, pw);
      wr(ADDR_PULSE_RATE, rate);
      wr(ADDR_PULSE_SEL, sel);
      wr(ADDR_CFG_ONE, en);
      repeat (WAIT_CYC) @(negedge clock);
   endtask
   task automatic clear();
      for (int p = 0; p < 3; p++) begin
         pulses[p] = 0;
         period[p] = 0;
         low_len[p] = 0;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Pins are sampled on the falling edge. The rising edge is where the
   // block launches them, and a read there would race that update.
   always @(negedge clock) begin
      cyc++;
      for (int p = 0; p < 3; p++) begin
         if (prev[p] && !do_out[p]) begin
            if (pulses[p] > 0) period[p] = cyc - fall_at[p];
            fall_at[p] = cyc;
            pulses[p]++;
         end
         if (!prev[p] && do_out[p]) low_len[p] = cyc - fall_at[p];
      end
      prev = do_out;
   end
endmodule

// *** verification/testbench.sv ***
/*
 Self-checking bench for channel selection and energy pulse generation.
 Assumes host_model drives the register port; generator counts shortened.
*/
module testbench;
   import tamper_pulse_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // Base 10 cycles, full scale 20 cycles; range 6, rate 0.5.
   localparam int LOW = 10 + PW_CYC_PER_LSB;
   localparam int PER_P = 20 * 64 * 4;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic sample_valid = 1'b0;
   logic signed [23:0] p1 = 0, p2 = 0, q1 = 24'h11_1111, q2 = 24'h22_2222;
   logic signed [23:0] s1 = 24'h33_3333, s2 = 24'h44_4444;
   logic [23:0] i1 = 0, i2 = 0, rv, reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, active_chan;
   logic [5:0] reg_addr;
   logic signed [23:0] psum, qsum, ssum;
   logic [2:0] do_out, do_oe;
   int bad_count = 0;
   int n_checks = 0;
   tamper_select_energy_pulse #(.BASE_CYCLES(10), .FS_CYCLES(20)) dut (
      .clock(clock), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sample_valid(sample_valid), .p1_avg(p1), .p2_avg(p2), .q1_avg(q1),
      .q2_avg(q2), .s1_avg(s1), .s2_avg(s2), .i1_rms(i1), .i2_rms(i2),
      .psum(psum), .qsum(qsum), .ssum(ssum), .active_chan(active_chan),
      .do_out(do_out), .do_oe(do_oe));
   host_model host (
      .clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .do_out(do_out));
   initial begin
      forever #12.5 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic sample(input logic [23:0] a, b, c, d);
      @(negedge clock);
      p1 = a;
      p2 = b;
      i1 = c;
      i2 = d;
      sample_valid = 1'b1;
      @(negedge clock);
      sample_valid = 1'b0;
   endtask
   task automatic sel_check(input logic ch, input logic [23:0] ps, qs, ss);
      check({23'h0, active_chan}, {23'h0, ch});
      check(psum, ps);
      check(qsum, qs);
      check(ssum, ss);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      logic [5:0] a[8] = '{ADDR_CFG_TWO, ADDR_CFG_ONE, ADDR_MIN_AMP,
         ADDR_CHAN_LEVEL, ADDR_FIXED_VOLTAGE_SUBSTITUTE_VALUE, ADDR_PULSE_WIDTH, ADDR_PULSE_SEL,
         ADDR_PULSE_RATE};
      logic [23:0] e[8] = '{24'h00_0000, 24'h00_0000, 24'h00_0000,
         24'h41_47AE, 24'hB5_04F7, 24'h00_0001, 24'h00_0000, 24'h00_0000};
      check({21'h0, do_oe}, 24'h00_0000);
      check({21'h0, do_out}, 24'h00_0007);
      for (int k = 0; k < 8; k++) begin
         host.rd(a[k], rv);
         check(rv, e[k]);
      end
      host.wr(6'h02, 24'hFF_FFFF);
      host.rd(6'h02, rv);
      check(rv, 24'h00_0000);
      $display("reset test done");
   endtask
   task automatic test_auto();
      host.wr(ADDR_MIN_AMP, 24'h10_0000);
      sample(24'h20_0000, 24'h20_8000, 0, 0);
      sel_check(0, 24'h20_0000, q1, s1);
      sample(24'h20_0000, 24'hDF_0000, 0, 0);
      sel_check(1, 24'hDF_0000, q2, s2);
      host.rd(ADDR_CFG_TWO, rv);
      check(rv, 24'h00_0100);
      sample(24'h0F_0000, 24'h01_0000, 0, 0);
      sel_check(1, 24'h01_0000, q2, s2);
      $display("auto select test done");
   endtask
   task automatic test_manual();
      host.wr(ADDR_CFG_TWO, 24'h00_0004);
      sample(24'h01_0000, 24'h30_0000, 24'h40_0000, 24'h10_0000);
      sel_check(0, 24'h01_0000, q1, s1);
      host.wr(ADDR_CFG_TWO, 24'h00_0018);
      sample(24'h70_0000, 24'h01_0000, 24'h70_0000, 24'h01_0000);
      sel_check(1, 24'h01_0000, q2, s2);
      host.wr(ADDR_CFG_TWO, 24'h00_0028);
      sample(24'h12_3456, 24'h01_0000, 24'h80_0000, 0);
      sel_check(0, 24'h2D_413D, q1, s1);
      host.wr(ADDR_FIXED_VOLTAGE_SUBSTITUTE_VALUE, 24'h40_0000);
      sample(24'h12_3456, 24'h01_0000, 24'h80_0000, 0);
      sel_check(0, 24'h10_0000, q1, s1);
      host.wr(ADDR_CFG_TWO, 24'h00_0001);
      sample(24'h10_0000, 24'h30_0000, 0, 0);
      sel_check(0, 24'h20_0000, 24'h19_9999, 24'h3B_BBBB);
      $display("manual and fixed voltage test done");
   endtask
   task automatic test_pulse();
      host.wr(ADDR_CFG_TWO, 24'h00_0008);
      q1 = 24'h20_0000;
      s1 = 24'h00_0000;
      sample(24'h40_0000, 24'h01_0000, 0, 0);
      host.pulse_setup(24'h60_0001, 24'h80_0000, 24'h00_0024, 24'h07_0000);
      check({21'h0, do_oe}, 24'h00_0000);
      host.wr(ADDR_CFG_ONE, 24'h07_0312);
      repeat (2) @(negedge clock);
      check({21'h0, do_oe}, 24'h00_0007);
      host.clear();
      repeat (31000) @(negedge clock);
      check(24'(host.period[1]), 24'(PER_P));
      check(24'(host.low_len[1]), 24'(LOW));
      check(24'(host.period[0]), 24'(2 * PER_P));
      check(24'(host.low_len[0]), 24'(LOW));
      check(24'(host.pulses[2]), 24'h00_0000);
      host.wr(ADDR_CFG_ONE, 24'h00_0312);
      repeat (LOW + 10) @(negedge clock);
      host.clear();
      repeat (6000) @(negedge clock);
      check(24'(host.pulses[1]), 24'h00_0000);
      check({21'h0, do_out}, 24'h00_0007);
      $display("pulse test done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(negedge clock);
      nrst = 1'b1;
      test_reset();
      test_auto();
      test_manual();
      test_pulse();
      end_sim();
   end
   // Whole run is about 40000 cycles, so this limit only trips on a hang.
   initial begin
      repeat (60000) @(posedge clock);
      bad_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule
